// ---- common/boot_req_pkg.sv ----
// Constants and types shared by the boot-time control request interpreter.
// How it works
// - Vendor OUT 0x91 writes wValue low byte to external memory at wIndex.
// - Vendor IN 0x92 returns one EEPROM byte from the wIndex address.
// - EEPROM read takes device number zero to seven from wValue high byte.
// - EEPROM read takes memory category zero to three from wValue bits 1:0.
// - Bit 7 of wValue low byte selects 400 kHz I2C speed.
// - Device number, category and speed persist from the last EEPROM read.
// - Vendor OUT 0x93 writes wValue low byte to EEPROM at wIndex.
// - Vendor request 0x94 returns boot ROM byte at wIndex address.
// - Request type MSB sets the direction bit before serving.
// - A decoded request is dropped if a newer setup is pending.
// - After serving, a pending setup sends the machine back to decode.
// - Completion clears the interrupt source first, then the vector register.
// - Handles control read and write transfers; interrupt per setup, IN, OUT.
// - Get-status returns device power/wakeup or endpoint stall status.
// - Get-status on an interface returns two zero bytes.
// - Device, configuration, string descriptors returned; interface, endpoint stalled.
// - Get-configuration and get-interface return stored values.
// - Clear-feature on endpoint unstalls if the direction bit is clear; on device or interface stalls.
// - Set-feature on endpoint stalls it if the direction bit is clear; on device or interface stalls.
// - Set-address, set-configuration, set-interface store; set-descriptor, synch-frame stall.
// - Vendor IN 0x90 returns the external memory byte at wIndex.
`default_nettype none

package boot_req_pkg;
	localparam logic [7:0] REQ_EXT_RD = 8'h90;
	localparam logic [7:0] REQ_EXT_WR = 8'h91;
	localparam logic [7:0] REQ_EE_RD = 8'h92;
	localparam logic [7:0] REQ_EE_WR = 8'h93;
	localparam logic [7:0] REQ_ROM_RD = 8'h94;
	localparam logic [7:0] STD_GET_STATUS = 8'h00;
	localparam logic [7:0] STD_CLR_FEATURE = 8'h01;
	localparam logic [7:0] STD_SET_FEATURE = 8'h03;
	localparam logic [7:0] STD_SET_ADDRESS = 8'h05;
	localparam logic [7:0] STD_GET_DESC = 8'h06;
	localparam logic [7:0] STD_SET_DESC = 8'h07;
	localparam logic [7:0] STD_GET_CONFIG = 8'h08;
	localparam logic [7:0] STD_SET_CONFIG = 8'h09;
	localparam logic [7:0] STD_GET_IFACE = 8'h0a;
	localparam logic [7:0] STD_SET_IFACE = 8'h0b;
	localparam logic [7:0] STD_SYNCH_FRAME = 8'h0c;
	localparam logic [1:0] TYPE_STANDARD = 2'h0;
	localparam logic [1:0] TYPE_VENDOR = 2'h2;
	localparam logic [1:0] RCPT_DEVICE = 2'h0;
	localparam logic [1:0] RCPT_IFACE = 2'h1;
	localparam logic [1:0] RCPT_ENDPOINT = 2'h2;
	localparam logic [7:0] DESC_DEVICE = 8'h01;
	localparam logic [7:0] DESC_CONFIG = 8'h02;
	localparam logic [7:0] DESC_STRING = 8'h03;
	localparam int DIR_BIT = 7;
	localparam int TYPE_LSB = 5;
	localparam int SPEED_BIT = 7;
	localparam logic [2:0] DEV_NUM_MAX = 3'h7;
	localparam logic [2:0] EE_DEV_RST = 3'h0;
	localparam logic [1:0] EE_CAT_RST = 2'h0;
	localparam int EE_CAT_BITS = 2;
	localparam logic [6:0] ADDR_RST = 7'h00;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [15:0] LEN_ONE = 16'h0001;

	typedef enum logic [3:0] {
		K_NONE, K_EXT_RD, K_EXT_WR, K_EE_RD, K_EE_WR, K_ROM_RD,
		K_STAT, K_DESC, K_CFG_RD, K_IF_RD, K_FEAT, K_ADDR, K_CFG_WR, K_IF_WR, K_STALL
	} kind_t;
endpackage : boot_req_pkg

`default_nettype wire

// ---- common/setup_if.sv ----
// Decoded setup fields passed from the decoder to the request sequencer.
`default_nettype none

interface setup_if;
	boot_req_pkg::kind_t kind;
	logic dir_in;
	logic [1:0] rcpt;
	logic [7:0] value_lo;
	logic [7:0] value_hi;
	logic [15:0] index;
	modport dec (output kind, dir_in, rcpt, value_lo, value_hi, index);
	modport seq (input kind, dir_in, rcpt, value_lo, value_hi, index);
endinterface : setup_if

`default_nettype wire

// ---- dv/mem_side_model.sv ----
// Far-side model of external memory, boot ROM, EEPROM and descriptor sender.
`default_nettype none

module mem_side_model (
	input wire logic clock,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic mem_ack,
	output logic [7:0] mem_rdata,
	input wire logic rom_req,
	input wire logic [15:0] rom_addr,
	output logic rom_ack,
	output logic [7:0] rom_rdata,
	input wire logic i2c_req,
	input wire logic i2c_we,
	input wire logic [15:0] i2c_addr,
	input wire logic [7:0] i2c_wdata,
	output logic i2c_ack,
	output logic [7:0] i2c_rdata,
	input wire logic desc_req,
	output logic desc_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	int lat = 1;
	int cnt = 0;
	logic [7:0] ext [int];
	logic [7:0] ee [int];

	initial begin
		{mem_ack, rom_ack, i2c_ack, desc_ack} = 4'h0;
		{mem_rdata, rom_rdata, i2c_rdata} = 24'h000000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read lines toggle every cycle outside an acknowledge, so a late sample shows up as wrong data.
	always @(negedge clock) begin
		{mem_ack, rom_ack, i2c_ack, desc_ack} <= 4'h0;
		mem_rdata <= ~mem_rdata;
		rom_rdata <= ~rom_rdata;
		i2c_rdata <= ~i2c_rdata;
		if (!(mem_req || rom_req || i2c_req || desc_req) || mem_ack || rom_ack || i2c_ack || desc_ack) begin
			cnt <= 0;
		end else if (cnt < lat) begin
			cnt <= cnt + 1;
		end else begin
			cnt <= 0;
			{mem_ack, rom_ack, i2c_ack, desc_ack} <= {mem_req, rom_req, i2c_req, desc_req};
			if (mem_req && mem_we) ext[mem_addr] = mem_wdata;
			if (i2c_req && i2c_we) ee[i2c_addr] = i2c_wdata;
			mem_rdata <= ext.exists(mem_addr) ? ext[mem_addr] : mem_addr[7:0] ^ 8'h5a;
			i2c_rdata <= ee.exists(i2c_addr) ? ee[i2c_addr] : 8'(i2c_addr[7:0] + i2c_addr[15:8]);
			rom_rdata <= rom_addr[7:0] ^ rom_addr[15:8];
		end
	end
endmodule : mem_side_model

`default_nettype wire

// ---- dv/usb_boot_request_handler_tb.sv ----
// Self-checking bench for the endpoint-zero request sequencer.
`default_nettype none

module usb_boot_request_handler_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0, nrst = 1'b0, setup_pending = 1'b0, token_in = 1'b0, token_out = 1'b0;
	logic self_powered = 1'b0, remote_wakeup = 1'b0;
	logic [7:0] req_type = 8'h00, req_code = 8'h00;
	logic [15:0] w_value = 16'h0000, w_index = 16'h0000, w_length = 16'h0000, ep_stall_status = 16'h0000;
	logic usb_event_irq, mem_req, mem_we, mem_ack, rom_req, rom_ack, i2c_req, i2c_we, i2c_ack, i2c_fast;
	logic desc_req, desc_ack, usb_dir_in, reply_valid, ep0_stall, ep_stall_set, ep_stall_clr;
	logic clr_irq_source, clr_interrupt_vector_register;
	logic [15:0] mem_addr, rom_addr, i2c_addr, desc_select, reply_data, rep, dsel, a, e, r;
	logic [7:0] mem_wdata, mem_rdata, rom_rdata, i2c_wdata, i2c_rdata, lrt, d, d2, cf;
	logic [7:0] stored_configuration_value, stored_interface_number;
	logic [2:0] i2c_dev_num, edev, dev;
	logic [1:0] i2c_category, reply_len, ecat, cat, rl;
	logic [3:0] ep_sel, esel;
	logic [6:0] usb_address;
	logic efast, fast, src_q, order_ok;
	int num_errors = 0, check_count = 0, n_wr, n_desc, n_set, n_clr, done = 0, d0, k;

	usb_boot_request_handler dut (.*);
	mem_side_model p (.*);

	always #25 clock = ~clock;

	////////////////////////////////////////////////////////////////////////////////
	// Observers sample design outputs before the edge updates them.
	always @(posedge clock) begin
		src_q <= clr_irq_source;
		if (reply_valid) {rep, rl} = {reply_data, reply_len};
		if (mem_req && mem_ack && mem_we) n_wr++;
		if (i2c_req && i2c_ack) {edev, ecat, efast} = {i2c_dev_num, i2c_category, i2c_fast};
		if (desc_req && desc_ack) begin n_desc++; dsel = desc_select; end
		if (ep_stall_set) begin n_set++; esel = ep_sel; end
		if (ep_stall_clr) begin n_clr++; esel = ep_sel; end
		if (clr_interrupt_vector_register) begin done++; order_ok = src_q; end
	end

	task automatic end_sim();
		if (num_errors == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic post(input logic [7:0] rt, input logic [7:0] rc, input logic [15:0] wv,
			input logic [15:0] wi, input logic [15:0] wl);
		@(negedge clock);
		lrt = rt;
		{req_type, req_code, w_value, w_index, w_length} = {rt, rc, wv, wi, wl};
		setup_pending = 1'b1;
	endtask : post

	task automatic wait_done();
		int n;
		for (n = 0; n < 300 && done == d0; n++) @(negedge clock);
		setup_pending = 1'b0;
		chk("completion", 16'h0001, 16'(done != d0));
		repeat (2) @(negedge clock);
		chk("clear order", 16'h0001, 16'(order_ok));
		chk("direction", 16'(lrt[7]), 16'(usb_dir_in));
	endtask : wait_done

	task automatic req(input logic [7:0] rt, input logic [7:0] rc, input logic [15:0] wv,
			input logic [15:0] wi, input logic [15:0] wl);
		d0 = done;
		{n_wr, n_desc, n_set, n_clr} = {4{32'sd0}};
		{rep, dsel, esel} = {32'hffffffff, 4'hf};
		post(rt, rc, wv, wi, wl);
		@(negedge clock);
		setup_pending = 1'b0;
		chk("setup event", 16'h0001, 16'(usb_event_irq));
		wait_done();
	endtask : req

	initial begin
		#1000000;
		num_errors++;
		end_sim();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(65));
		repeat (8) @(posedge clock);
		@(negedge clock);
		nrst = 1'b1;
		{a, d, d2, cf} = {16'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)};
		req(8'h40, boot_req_pkg::REQ_EXT_WR, {8'h00, d}, a, 16'h0000);
		chk("ext write data", 16'(d), 16'(p.ext[a]));
		req(8'hc0, boot_req_pkg::REQ_EXT_RD, 16'h0000, a, 16'h0001);
		chk("ext read", 16'(d), 16'(rep[7:0]));
		chk("read length", 16'h0001, 16'(rl));
		{e, dev, cat, fast} = {16'($urandom), 3'($urandom), 2'($urandom_range(3, 1)), 1'($urandom)};
		req(8'hc0, boot_req_pkg::REQ_EE_RD, {5'h00, dev, fast, 5'h00, cat}, e, 16'h0001);
		chk("eeprom read", 16'(8'(e[7:0] + e[15:8])), 16'(rep[7:0]));
		chk("eeprom dev", 16'(dev), 16'(edev));
		chk("eeprom cat", 16'(cat), 16'(ecat));
		chk("eeprom fast", 16'(fast), 16'(efast));
		edev = ~dev;
		p.lat = 4;
		req(8'h40, boot_req_pkg::REQ_EE_WR, {8'h00, d2}, e, 16'h0000);
		chk("eeprom write", 16'(d2), 16'(p.ee[e]));
		chk("kept settings", 16'({dev, cat, fast}), 16'({edev, ecat, efast}));
		req(8'hc0, boot_req_pkg::REQ_EE_RD, 16'h0801, e, 16'h0001);
		chk("bad dev stall", 16'h0001, 16'(ep0_stall));
		r = 16'($urandom);
		req(8'h40, boot_req_pkg::REQ_ROM_RD, 16'h0000, r, 16'h0001);
		chk("rom read", 16'(r[7:0] ^ r[15:8]), 16'(rep[7:0]));
		chk("served no stall", 16'h0000, 16'(ep0_stall));
		req(8'hc0, 8'h95, 16'h0000, 16'h0000, 16'h0001);
		chk("vendor stall", 16'h0001, 16'(ep0_stall));
		req(8'hc0, boot_req_pkg::REQ_EXT_RD, 16'h0000, a, 16'h0002);
		chk("bad length stall", 16'h0001, 16'(ep0_stall));
		{self_powered, remote_wakeup, ep_stall_status} = {2'($urandom), 16'($urandom)};
		req(8'h80, boot_req_pkg::STD_GET_STATUS, 16'h0000, 16'h0000, 16'h0002);
		chk("dev status", {14'h0000, remote_wakeup, self_powered}, rep);
		chk("status length", 16'h0002, 16'(rl));
		req(8'h81, boot_req_pkg::STD_GET_STATUS, 16'h0000, 16'h0000, 16'h0002);
		chk("iface status", 16'h0000, rep);
		req(8'h82, boot_req_pkg::STD_GET_STATUS, 16'h0000, 16'h0005, 16'h0002);
		chk("ep status", 16'(ep_stall_status[5]), rep);
		for (k = 1; k <= 5; k++) begin
			req(8'h80, boot_req_pkg::STD_GET_DESC, {k[7:0], 8'h00}, 16'h0000, 16'h0012);
			if (k <= 3) chk("desc select", {k[7:0], 8'h00}, dsel);
			else chk("desc stall", 16'h0001, 16'(ep0_stall));
		end
		req(8'h00, boot_req_pkg::STD_SET_CONFIG, {8'h00, cf}, 16'h0000, 16'h0000);
		req(8'h80, boot_req_pkg::STD_GET_CONFIG, 16'h0000, 16'h0000, 16'h0001);
		chk("config", {cf, cf}, {stored_configuration_value, rep[7:0]});
		req(8'h01, boot_req_pkg::STD_SET_IFACE, {8'h00, d}, 16'h0000, 16'h0000);
		req(8'h81, boot_req_pkg::STD_GET_IFACE, 16'h0000, 16'h0000, 16'h0001);
		chk("iface", {d, d}, {stored_interface_number, rep[7:0]});
		req(8'h00, boot_req_pkg::STD_SET_ADDRESS, {9'h000, cf[6:0]}, 16'h0000, 16'h0000);
		chk("address", 16'(cf[6:0]), 16'(usb_address));
		req(8'h02, boot_req_pkg::STD_SET_FEATURE, 16'h0000, 16'h0003, 16'h0000);
		chk("ep stall set", 16'h0013, 16'({n_set[3:0], esel}));
		req(8'h02, boot_req_pkg::STD_CLR_FEATURE, 16'h0000, 16'h0003, 16'h0000);
		chk("ep stall clr", 16'h0013, 16'({n_clr[3:0], esel}));
		for (k = 0; k < 4; k++) begin
			req(8'(k[0]), k[1] ? boot_req_pkg::STD_SET_FEATURE : boot_req_pkg::STD_CLR_FEATURE,
				16'h0000, 16'h0000, 16'h0000);
			chk("feature stall", 16'h0001, 16'(ep0_stall));
		end
		req(8'h00, boot_req_pkg::STD_SET_DESC, 16'h0100, 16'h0000, 16'h0000);
		chk("set desc stall", 16'h0001, 16'(ep0_stall));
		req(8'h82, boot_req_pkg::STD_SYNCH_FRAME, 16'h0000, 16'h0001, 16'h0002);
		chk("synch stall", 16'h0001, 16'(ep0_stall));
		for (k = 0; k < 2; k++) begin
			@(negedge clock);
			chk("event idle", 16'h0000, 16'(usb_event_irq));
			{token_in, token_out} = k[0] ? 2'b10 : 2'b01;
			@(negedge clock);
			{token_in, token_out} = 2'b00;
			chk("token event", 16'h0001, 16'(usb_event_irq));
		end
		// A second setup arrives while the first waits on a slow memory acknowledge.
		{d0, n_wr} = {done, 32'sd0};
		post(8'h40, boot_req_pkg::REQ_EXT_WR, {8'h00, d}, a ^ 16'h0001, 16'h0000);
		@(negedge clock);
		setup_pending = 1'b0;
		for (k = 0; k < 50 && !mem_req; k++) @(negedge clock);
		post(8'h40, boot_req_pkg::REQ_EXT_WR, {8'h00, d2}, a ^ 16'h0002, 16'h0000);
		for (k = 0; k < 50 && !mem_ack; k++) @(posedge clock);
		repeat (2) @(posedge clock);
		@(negedge clock);
		setup_pending = 1'b0;
		wait_done();
		chk("redecoded write", 16'({8'(n_wr), d2}), 16'({8'h02, p.ext[a ^ 16'h0002]}));
		// A newer setup pending at serve time must drop the older request.
		{d0, n_wr} = {done, 32'sd0};
		post(8'h40, boot_req_pkg::REQ_EXT_WR, {8'h00, d}, a ^ 16'h0004, 16'h0000);
		@(negedge clock);
		setup_pending = 1'b0;
		@(negedge clock);
		post(8'h00, boot_req_pkg::STD_SET_ADDRESS, 16'h0011, 16'h0000, 16'h0000);
		wait_done();
		repeat (12) @(negedge clock);
		chk("abandoned write", 16'h0000, 16'({8'(n_wr), 7'h00, p.ext.exists(a ^ 16'h0004)}));
		chk("newer served", 16'h0011, 16'(usb_address));
		end_sim();
	end
endmodule : usb_boot_request_handler_tb

`default_nettype wire

// ---- rtl/setup_decode.sv ----
// Combinational classifier of an eight-byte setup packet.
`default_nettype none

module setup_decode (
	input wire logic [7:0] req_type,
	input wire logic [7:0] req_code,
	input wire logic [15:0] w_value,
	input wire logic [15:0] w_index,
	input wire logic [15:0] w_length,
	setup_if.dec sif
);
	function automatic boot_req_pkg::kind_t classify(input logic [7:0] rt, input logic [7:0] rc,
			input logic [15:0] wv, input logic [15:0] wl);
		logic [1:0] ty;
		logic [1:0] rp;
		boot_req_pkg::kind_t k;
		ty = rt[boot_req_pkg::TYPE_LSB +: 2];
		rp = rt[1:0];
		k = boot_req_pkg::K_STALL;
		if (ty == boot_req_pkg::TYPE_VENDOR) begin
			case (rc)
				boot_req_pkg::REQ_EXT_RD: if (wl == boot_req_pkg::LEN_ONE) k = boot_req_pkg::K_EXT_RD;
				boot_req_pkg::REQ_EXT_WR: if (wl == boot_req_pkg::ZERO16 && wv[15:8] == 8'h00) k = boot_req_pkg::K_EXT_WR;
				boot_req_pkg::REQ_EE_RD: if (wl == boot_req_pkg::LEN_ONE && wv[15:8] <= {5'h00, boot_req_pkg::DEV_NUM_MAX})
					k = boot_req_pkg::K_EE_RD;
				boot_req_pkg::REQ_EE_WR: if (wl == boot_req_pkg::ZERO16) k = boot_req_pkg::K_EE_WR;
				boot_req_pkg::REQ_ROM_RD: if (wl == boot_req_pkg::LEN_ONE) k = boot_req_pkg::K_ROM_RD;
				default: k = boot_req_pkg::K_STALL;
			endcase
		end else if (ty == boot_req_pkg::TYPE_STANDARD) begin
			case (rc)
				boot_req_pkg::STD_GET_STATUS: k = boot_req_pkg::K_STAT;
				boot_req_pkg::STD_GET_DESC: begin
					if (wv[15:8] == boot_req_pkg::DESC_DEVICE || wv[15:8] == boot_req_pkg::DESC_CONFIG
							|| wv[15:8] == boot_req_pkg::DESC_STRING)
						k = boot_req_pkg::K_DESC;
				end
				boot_req_pkg::STD_GET_CONFIG: k = boot_req_pkg::K_CFG_RD;
				boot_req_pkg::STD_GET_IFACE: k = boot_req_pkg::K_IF_RD;
				boot_req_pkg::STD_CLR_FEATURE, boot_req_pkg::STD_SET_FEATURE: begin
					if (rp == boot_req_pkg::RCPT_ENDPOINT) k = boot_req_pkg::K_FEAT;
				end
				boot_req_pkg::STD_SET_ADDRESS: k = boot_req_pkg::K_ADDR;
				boot_req_pkg::STD_SET_CONFIG: k = boot_req_pkg::K_CFG_WR;
				boot_req_pkg::STD_SET_IFACE: k = boot_req_pkg::K_IF_WR;
				default: k = boot_req_pkg::K_STALL;
			endcase
		end
		return k;
	endfunction : classify

	always_comb begin
		sif.kind = classify(req_type, req_code, w_value, w_length);
		sif.dir_in = req_type[boot_req_pkg::DIR_BIT];
		sif.rcpt = req_type[1:0];
		sif.value_lo = w_value[7:0];
		sif.value_hi = w_value[15:8];
		sif.index = w_index;
	end
endmodule : setup_decode

`default_nettype wire

// ---- rtl/usb_boot_request_handler.sv ----
// Endpoint-zero request sequencer serving vendor memory requests and standard requests.
`default_nettype none

module usb_boot_request_handler (
	input wire logic clock,
	input wire logic nrst,
	input wire logic setup_pending,
	input wire logic [7:0] req_type,
	input wire logic [7:0] req_code,
	input wire logic [15:0] w_value,
	input wire logic [15:0] w_index,
	input wire logic [15:0] w_length,
	input wire logic token_in,
	input wire logic token_out,
	input wire logic self_powered,
	input wire logic remote_wakeup,
	input wire logic [15:0] ep_stall_status,
	output logic usb_event_irq,
	output logic mem_req,
	output logic mem_we,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	output logic rom_req,
	output logic [15:0] rom_addr,
	input wire logic rom_ack,
	input wire logic [7:0] rom_rdata,
	output logic i2c_req,
	output logic i2c_we,
	output logic [2:0] i2c_dev_num,
	output logic [1:0] i2c_category,
	output logic i2c_fast,
	output logic [15:0] i2c_addr,
	output logic [7:0] i2c_wdata,
	input wire logic i2c_ack,
	input wire logic [7:0] i2c_rdata,
	output logic desc_req,
	output logic [15:0] desc_select,
	input wire logic desc_ack,
	output logic usb_dir_in,
	output logic [1:0] reply_len,
	output logic [15:0] reply_data,
	output logic reply_valid,
	output logic ep0_stall,
	output logic ep_stall_set,
	output logic ep_stall_clr,
	output logic [3:0] ep_sel,
	output logic [6:0] usb_address,
	output logic [7:0] stored_configuration_value,
	output logic [7:0] stored_interface_number,
	output logic clr_irq_source,
	output logic clr_interrupt_vector_register
);
	typedef enum logic [2:0] {S_IDLE, S_DIR, S_DECODE, S_SERVE, S_WAIT, S_RECHECK, S_CLR_SRC, S_CLR_VEC} state_t;

	typedef struct packed {
		state_t st;
		boot_req_pkg::kind_t kind;
		logic [1:0] rcpt;
		logic [7:0] vlo;
		logic [7:0] vhi;
		logic [15:0] idx;
		logic dir_in;
		logic [2:0] dev;
		logic [1:0] cat;
		logic fast;
		logic [6:0] addr;
		logic [7:0] cfg;
		logic [7:0] ifc;
		logic fset;
		logic mreq;
		logic mwe;
		logic [7:0] mwdata;
		logic rreq;
		logic ireq;
		logic iwe;
		logic dreq;
		logic [1:0] rlen;
		logic [15:0] rdata;
		logic rvalid;
		logic stall;
		logic sset;
		logic sclr;
		logic csrc;
		logic cvec;
		logic evt;
	} regs_t;

	setup_if sif ();
	regs_t r;
	regs_t nxt;

	setup_decode u_decode (
		.req_type(req_type),
		.req_code(req_code),
		.w_value(w_value),
		.w_index(w_index),
		.w_length(w_length),
		.sif(sif)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer.

	always_comb begin
		nxt = r;
		nxt.sset = 1'b0;
		nxt.sclr = 1'b0;
		nxt.csrc = 1'b0;
		nxt.cvec = 1'b0;
		nxt.rvalid = 1'b0;
		// Every setup and every data-stage token raises one event pulse.
		nxt.evt = setup_pending | token_in | token_out;
		case (r.st)
			S_IDLE: begin
				if (setup_pending) begin
					nxt.st = S_DIR;
				end
			end
			S_DIR: begin
				nxt.dir_in = sif.dir_in;
				nxt.stall = 1'b0;
				nxt.st = S_DECODE;
			end
			S_DECODE: begin
				nxt.kind = sif.kind;
				nxt.rcpt = sif.rcpt;
				nxt.vlo = sif.value_lo;
				nxt.vhi = sif.value_hi;
				nxt.idx = sif.index;
				nxt.dir_in = sif.dir_in;
				// The setup fields need not hold past decode, and a redecoded setup skips the direction step.
				nxt.fset = req_code[1];
				nxt.stall = 1'b0;
				nxt.st = S_SERVE;
			end
			S_SERVE: begin
				// A newer setup overrides the decoded one before any side effect.
				if (setup_pending) begin
					nxt.st = S_CLR_SRC;
				end else begin
					nxt.st = S_RECHECK;
					case (r.kind)
						boot_req_pkg::K_EXT_RD: begin
							nxt.mreq = 1'b1;
							nxt.mwe = 1'b0;
							nxt.st = S_WAIT;
						end
						boot_req_pkg::K_EXT_WR: begin
							nxt.mreq = 1'b1;
							nxt.mwe = 1'b1;
							nxt.mwdata = r.vlo;
							nxt.st = S_WAIT;
						end
						boot_req_pkg::K_EE_RD: begin
							nxt.dev = r.vhi[2:0];
							nxt.cat = r.vlo[boot_req_pkg::EE_CAT_BITS-1:0];
							nxt.fast = r.vlo[boot_req_pkg::SPEED_BIT];
							nxt.ireq = 1'b1;
							nxt.iwe = 1'b0;
							nxt.st = S_WAIT;
						end
						boot_req_pkg::K_EE_WR: begin
							nxt.ireq = 1'b1;
							nxt.iwe = 1'b1;
							nxt.mwdata = r.vlo;
							nxt.st = S_WAIT;
						end
						boot_req_pkg::K_ROM_RD: begin
							nxt.rreq = 1'b1;
							nxt.st = S_WAIT;
						end
						boot_req_pkg::K_STAT: begin
							nxt.rlen = 2'h2;
							nxt.rvalid = 1'b1;
							case (r.rcpt)
								boot_req_pkg::RCPT_DEVICE: nxt.rdata = {14'h0000, remote_wakeup, self_powered};
								boot_req_pkg::RCPT_ENDPOINT: nxt.rdata = {15'h0000, ep_stall_status[r.idx[3:0]]};
								default: nxt.rdata = boot_req_pkg::ZERO16;
							endcase
						end
						boot_req_pkg::K_DESC: begin
							nxt.dreq = 1'b1;
							nxt.st = S_WAIT;
						end
						boot_req_pkg::K_CFG_RD: begin
							nxt.rlen = 2'h1;
							nxt.rdata = {8'h00, r.cfg};
							nxt.rvalid = 1'b1;
						end
						boot_req_pkg::K_IF_RD: begin
							nxt.rlen = 2'h1;
							nxt.rdata = {8'h00, r.ifc};
							nxt.rvalid = 1'b1;
						end
						boot_req_pkg::K_FEAT: begin
							// Bit 1 of the code separates set-feature from clear-feature.
							nxt.sset = r.dir_in ? 1'b0 : r.fset;
							nxt.sclr = r.dir_in ? 1'b0 : ~r.fset;
						end
						boot_req_pkg::K_ADDR: nxt.addr = r.vlo[6:0];
						boot_req_pkg::K_CFG_WR: nxt.cfg = r.vlo;
						boot_req_pkg::K_IF_WR: nxt.ifc = r.vlo;
						default: nxt.stall = 1'b1;
					endcase
				end
			end
			S_WAIT: begin
				if (r.mreq && mem_ack) begin
					nxt.mreq = 1'b0;
					nxt.st = S_RECHECK;
					if (!r.mwe) begin
						nxt.rlen = 2'h1;
						nxt.rdata = {8'h00, mem_rdata};
						nxt.rvalid = 1'b1;
					end
				end else if (r.ireq && i2c_ack) begin
					nxt.ireq = 1'b0;
					nxt.st = S_RECHECK;
					if (!r.iwe) begin
						nxt.rlen = 2'h1;
						nxt.rdata = {8'h00, i2c_rdata};
						nxt.rvalid = 1'b1;
					end
				end else if (r.rreq && rom_ack) begin
					nxt.rreq = 1'b0;
					nxt.st = S_RECHECK;
					nxt.rlen = 2'h1;
					nxt.rdata = {8'h00, rom_rdata};
					nxt.rvalid = 1'b1;
				end else if (r.dreq && desc_ack) begin
					nxt.dreq = 1'b0;
					nxt.st = S_RECHECK;
				end
			end
			S_RECHECK: begin
				nxt.st = setup_pending ? S_DECODE : S_CLR_SRC;
			end
			S_CLR_SRC: begin
				nxt.csrc = 1'b1;
				nxt.st = S_CLR_VEC;
			end
			S_CLR_VEC: begin
				nxt.cvec = 1'b1;
				nxt.st = S_IDLE;
			end
			default: nxt.st = S_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			r <= '0;
			r.st <= S_IDLE;
			r.kind <= boot_req_pkg::K_NONE;
			r.dev <= boot_req_pkg::EE_DEV_RST;
			r.cat <= boot_req_pkg::EE_CAT_RST;
			r.addr <= boot_req_pkg::ADDR_RST;
			r.cfg <= boot_req_pkg::CFG_RST;
			r.ifc <= boot_req_pkg::CFG_RST;
		end else begin
			r <= nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.

	always_comb begin
		usb_event_irq = r.evt;
		mem_req = r.mreq;
		mem_we = r.mwe;
		mem_addr = r.idx;
		mem_wdata = r.mwdata;
		rom_req = r.rreq;
		rom_addr = r.idx;
		i2c_req = r.ireq;
		i2c_we = r.iwe;
		i2c_dev_num = r.dev;
		i2c_category = r.cat;
		i2c_fast = r.fast;
		i2c_addr = r.idx;
		i2c_wdata = r.mwdata;
		desc_req = r.dreq;
		desc_select = {r.vhi, r.vlo};
		usb_dir_in = r.dir_in;
		reply_len = r.rlen;
		reply_data = r.rdata;
		reply_valid = r.rvalid;
		ep0_stall = r.stall;
		ep_stall_set = r.sset;
		ep_stall_clr = r.sclr;
		ep_sel = r.idx[3:0];
		usb_address = r.addr;
		stored_configuration_value = r.cfg;
		stored_interface_number = r.ifc;
		clr_irq_source = r.csrc;
		clr_interrupt_vector_register = r.cvec;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	chk_vec_after_src: assert property (@(posedge clock) disable iff (!nrst)
		r.csrc |=> r.cvec) else $error("vector clear did not follow source clear");
	chk_vec_order: assert property (@(posedge clock) disable iff (!nrst)
		r.cvec |-> $past(r.csrc)) else $error("vector cleared before source");
	chk_abandon: assert property (@(posedge clock) disable iff (!nrst)
		(r.st == S_SERVE && setup_pending) |=> (r.st == S_CLR_SRC && !r.mreq && !r.ireq))
		else $error("request served despite pending setup");
	chk_recheck: assert property (@(posedge clock) disable iff (!nrst)
		(r.st == S_RECHECK && setup_pending) |=> r.st == S_DECODE) else $error("pending setup not redecoded");
	chk_dir_bit: assert property (@(posedge clock) disable iff (!nrst)
		r.st == S_DIR |=> r.dir_in == $past(req_type[7])) else $error("direction bit mismatch");
	chk_ext_wr: assert property (@(posedge clock) disable iff (!nrst)
		(r.st == S_SERVE && !setup_pending && r.kind == boot_req_pkg::K_EXT_WR)
		|=> (mem_req && mem_we && mem_wdata == $past(r.vlo))) else $error("external write not issued");
	chk_ee_speed: assert property (@(posedge clock) disable iff (!nrst)
		(r.st == S_SERVE && !setup_pending && r.kind == boot_req_pkg::K_EE_RD)
		|=> i2c_fast == $past(r.vlo[7])) else $error("I2C speed not taken");
	chk_ee_keep: assert property (@(posedge clock) disable iff (!nrst)
		(r.kind != boot_req_pkg::K_EE_RD) |=> $stable(i2c_dev_num)) else $error("EEPROM settings changed");
	chk_unknown_stall: assert property (@(posedge clock) disable iff (!nrst)
		(r.st == S_SERVE && !setup_pending && r.kind == boot_req_pkg::K_STALL) |=> ep0_stall)
		else $error("unknown request not stalled");
	chk_iface_zero: assert property (@(posedge clock) disable iff (!nrst)
		(r.st == S_SERVE && !setup_pending && r.kind == boot_req_pkg::K_STAT && r.rcpt == boot_req_pkg::RCPT_IFACE)
		|=> (reply_valid && reply_len == 2'h2 && reply_data == 16'h0000)) else $error("interface status not zero");
endmodule : usb_boot_request_handler

`default_nettype wire
